// File: common/fssr_pkg.sv
// Purpose: constants and carriers for the flash status register block
// Assumes: byte one/two layout, opcodes and field slots below
// Notes: status write opcode for byte two is a local choice
`default_nettype none
package fssr_pkg;
    // opcodes
    localparam logic [7:0] FSSR_OP_RD_STAT = 8'h05;
    localparam logic [7:0] FSSR_OP_WR_STAT1 = 8'h01;
    localparam logic [7:0] FSSR_OP_WR_STAT2 = 8'h31;
    // byte one fields
    localparam int FSSR_B1_LOCK = 7;
    localparam int FSSR_B1_RES = 6;
    localparam int FSSR_B1_EPE = 5;
    localparam int FSSR_B1_WPP = 4;
    localparam int FSSR_B1_SWP_HI = 3;
    localparam int FSSR_B1_SWP_LO = 2;
    localparam int FSSR_B1_WEL = 1;
    localparam int FSSR_BUSY = 0;
    // byte two fields
    localparam int FSSR_B2_RES_HI = 7;
    localparam int FSSR_B2_RES_LO = 5;
    localparam int FSSR_B2_RST_EN = 4;
    localparam int FSSR_B2_PERM = 3;
    localparam int FSSR_B2_PS = 2;
    localparam int FSSR_B2_ES = 1;
    localparam logic [2:0] FSSR_B2_RES_VAL = 3'h0;
    localparam logic FSSR_RES_VAL = 1'b0;
    // reset values and levels
    localparam logic FSSR_LOCK_RST = 1'b0;
    localparam logic FSSR_RST_EN_RST = 1'b0;
    localparam logic FSSR_PERM_RST = 1'b0;
    localparam logic FSSR_WP_ASSERTED = 1'b0;
    localparam logic [2:0] FSSR_BIT_FIRST = 3'h0;
    localparam logic [2:0] FSSR_BIT_LAST = 3'h7;
    localparam logic [2:0] FSSR_BIT_ONE = 3'h1;

    typedef enum logic [1:0] {
        FSSR_WK_NONE = 2'b00,
        FSSR_WK_ONE = 2'b01,
        FSSR_WK_TWO = 2'b10
    } fssr_wr_kind_t;

    typedef enum logic [1:0] {
        FSSR_FM_OPCODE = 2'b00,
        FSSR_FM_READ = 2'b01,
        FSSR_FM_WDATA = 2'b10,
        FSSR_FM_IGNORE = 2'b11
    } fssr_mode_t;

    typedef struct packed {
        logic busy;
        logic ep_error;
        logic [1:0] software_protection_summary;
        logic write_enable_latch;
        logic prog_susp;
        logic erase_susp;
    } fssr_core_in_t;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
    } fssr_stat_t;

    typedef struct packed {
        fssr_wr_kind_t kind;
        logic [7:0] data;
        logic full;
        logic partial;
    } fssr_cap_t;

    typedef struct packed {
        logic lock;
        logic rst_en;
        logic perm_en;
        logic cs_d;
        logic cs_dd;
        logic sect_allow;
        logic soft_go;
        logic wel_clr;
        fssr_stat_t stat;
    } fssr_sys_st_t;

    typedef struct packed {
        logic [2:0] bitn;
        logic [7:0] shift;
        fssr_mode_t mode;
    } fssr_lnk_st_t;

    typedef struct packed {
        logic so;
        logic oe;
        logic [2:0] obit;
        logic sel;
        logic [6:0] shift;
    } fssr_out_st_t;
endpackage
`default_nettype wire

// File: core/fssr_sync.sv
// Purpose: two-stage level synchroniser
// Assumes: input bits stable or independent when sampled
// Notes: no reset; first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module fssr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fssr_sync_st_t;

    fssr_sync_st_t st_q;
    fssr_sync_st_t st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign q = st_q.s2;
endmodule // fssr_sync
`default_nettype wire

// File: core/fssr_status_reg.sv
// Purpose: two-byte status register and its serial read/write commands
// Assumes: host drives sck and cs_n in mode 0 or 3
// Notes: sck runs only inside frames; cs_n high clears link shifter and output, not capture
//
// Contract
// - opcode 05h starts status output next clock
// - after byte two, output restarts at byte one
// - each byte freshly sampled, busy per byte
// - status read accepted at any time
// - chip select high ends read, output floats
// - byte one bit 7 is lock flag
// - reserved bits read as zero
// - byte one bit 5 shows erase/program error
// - byte one bit 4 shows protect pin
// - byte one bits 3:2 protection summary
// - byte one bit 1 shows write enable
// - bit 0 of both bytes is busy
// - byte two bit 4 soft reset enable
// - byte two bit 3 permanent lock enable
// - byte two bits 2,1 suspend flags
// - byte one write changes only bit 7
// - byte two write changes bits 4,3 only
// - lock set blocks sector protect commands
// - lock clears at reset, soft reset keeps
// - pin asserted: lock may only rise
// - soft reset ignored while enable is zero
// - write needs enable latch, acts at deselect
`timescale 1ns/1ns
`default_nettype none
module fssr_status_reg
    import fssr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic so,
    output logic so_oe,
    input wire logic wp_n,
    input wire fssr_core_in_t core_in,
    input wire logic soft_reset_req,
    output logic protection_lock_flag,
    output logic soft_reset_enable,
    output logic permanent_lock_enable,
    output logic sector_cmd_allowed,
    output logic soft_reset_go,
    output logic wel_clear
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic fssr_wr_kind_t fssr_kind(input logic [7:0] op);
        fssr_wr_kind_t k;
        k = FSSR_WK_NONE;
        if (op == FSSR_OP_WR_STAT1) begin
            k = FSSR_WK_ONE;
        end else if (op == FSSR_OP_WR_STAT2) begin
            k = FSSR_WK_TWO;
        end
        return k;
    endfunction

    function automatic fssr_mode_t fssr_decode(input logic [7:0] op);
        fssr_mode_t m;
        m = FSSR_FM_IGNORE;
        if (op == FSSR_OP_RD_STAT) begin
            m = FSSR_FM_READ;
        end else if (fssr_kind(op) != FSSR_WK_NONE) begin
            m = FSSR_FM_WDATA;
        end
        return m;
    endfunction

    fssr_sys_st_t st_q;
    fssr_sys_st_t st_d;
    fssr_lnk_st_t lk_q;
    fssr_lnk_st_t lk_d;
    fssr_cap_t cap_q;
    fssr_cap_t cap_d;
    fssr_out_st_t out_q;
    fssr_out_st_t out_d;
    fssr_stat_t stat_l;
    fssr_cap_t cap_s;
    logic cs_s;
    logic wp_s;
    logic cs_rise;
    logic wp_as;
    logic [7:0] shn;
    logic [7:0] obyte;

    // ----------------------------------------
    // crossings
    // ----------------------------------------
    // capture is quasi-static while cs_n is high, so a plain
    // level sync is safe once the delayed deselect edge is seen
    fssr_sync #(.W(14)) u_sys_sync (
        .clk(clk_sys),
        .d({cs_n, wp_n, cap_q}),
        .q({cs_s, wp_s, cap_s})
    );

    // status lands two sck edges late; stale only during the opcode
    fssr_sync #(.W(16)) u_lnk_sync (
        .clk(sck),
        .d(st_q.stat),
        .q(stat_l)
    );

    // ----------------------------------------
    // link side: opcode and data shifter
    // ----------------------------------------
    assign shn = {lk_q.shift[6:0], mosi};

    always_comb begin
        lk_d = lk_q;
        lk_d.shift = shn;
        lk_d.bitn = lk_q.bitn + FSSR_BIT_ONE;
        if (lk_q.mode == FSSR_FM_OPCODE && lk_q.bitn == FSSR_BIT_LAST) begin
            lk_d.mode = fssr_decode(shn);
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // no reset: cleared on the first edge of every frame
    always_comb begin
        cap_d = cap_q;
        if (lk_q.mode == FSSR_FM_OPCODE) begin
            if (lk_q.bitn == FSSR_BIT_FIRST) begin
                cap_d = '0;
            end
            if (lk_q.bitn == FSSR_BIT_LAST) begin
                cap_d.kind = fssr_kind(shn);
            end
        end else if (lk_q.mode == FSSR_FM_WDATA) begin
            cap_d.partial = (lk_q.bitn != FSSR_BIT_LAST);
            if (lk_q.bitn == FSSR_BIT_LAST && !cap_q.full) begin
                cap_d.data = shn;
                cap_d.full = 1'b1;
            end
        end
    end

    always_ff @(posedge sck) begin
        cap_q <= cap_d;
    end

    // ----------------------------------------
    // link side: status output on falling edge
    // ----------------------------------------
    assign obyte = out_q.sel ? stat_l.b2 : stat_l.b1;

    always_comb begin
        out_d = out_q;
        out_d.oe = 1'b0;
        if (lk_q.mode == FSSR_FM_READ) begin
            out_d.oe = 1'b1;
            out_d.obit = out_q.obit + FSSR_BIT_ONE;
            if (out_q.obit == FSSR_BIT_FIRST) begin
                out_d.so = obyte[7];
                out_d.shift = obyte[6:0];
            end else begin
                out_d.so = out_q.shift[6];
                out_d.shift = {out_q.shift[5:0], 1'b0};
            end
            if (out_q.obit == FSSR_BIT_LAST) begin
                out_d.sel = !out_q.sel;
            end
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    // ----------------------------------------
    // system side: register bits and writes
    // ----------------------------------------
    assign cs_rise = st_q.cs_d && !st_q.cs_dd;
    assign wp_as = (wp_s == FSSR_WP_ASSERTED);

    always_comb begin
        st_d = st_q;
        st_d.cs_d = cs_s;
        st_d.cs_dd = st_q.cs_d;
        st_d.wel_clr = 1'b0;
        st_d.soft_go = soft_reset_req && st_q.rst_en;
        if (cs_rise && cap_s.kind != FSSR_WK_NONE) begin
            st_d.wel_clr = 1'b1;
            if (cap_s.full && !cap_s.partial && core_in.write_enable_latch) begin
                if (cap_s.kind == FSSR_WK_ONE) begin
                    // only the lock bit is taken from the data
                    if (!(wp_as && st_q.lock && !cap_s.data[FSSR_B1_LOCK])) begin
                        st_d.lock = cap_s.data[FSSR_B1_LOCK];
                    end
                end else begin
                    st_d.rst_en = cap_s.data[FSSR_B2_RST_EN];
                    st_d.perm_en = cap_s.data[FSSR_B2_PERM];
                end
            end
        end
        st_d.sect_allow = !st_d.lock;
        st_d.stat.b1[FSSR_B1_LOCK] = st_q.lock;
        st_d.stat.b1[FSSR_B1_RES] = FSSR_RES_VAL;
        st_d.stat.b1[FSSR_B1_EPE] = core_in.ep_error;
        st_d.stat.b1[FSSR_B1_WPP] = wp_s;
        st_d.stat.b1[FSSR_B1_SWP_HI:FSSR_B1_SWP_LO] = core_in.software_protection_summary;
        st_d.stat.b1[FSSR_B1_WEL] = core_in.write_enable_latch;
        st_d.stat.b1[FSSR_BUSY] = core_in.busy;
        st_d.stat.b2[FSSR_B2_RES_HI:FSSR_B2_RES_LO] = FSSR_B2_RES_VAL;
        st_d.stat.b2[FSSR_B2_RST_EN] = st_q.rst_en;
        st_d.stat.b2[FSSR_B2_PERM] = st_q.perm_en;
        st_d.stat.b2[FSSR_B2_PS] = core_in.prog_susp;
        st_d.stat.b2[FSSR_B2_ES] = core_in.erase_susp;
        st_d.stat.b2[FSSR_BUSY] = core_in.busy;
    end

    // soft reset never touches lock or enables; only rst_n does
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.lock <= FSSR_LOCK_RST;
            st_q.rst_en <= FSSR_RST_EN_RST;
            st_q.perm_en <= FSSR_PERM_RST;
            st_q.cs_d <= 1'b1;
            st_q.cs_dd <= 1'b1;
            st_q.sect_allow <= !FSSR_LOCK_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign so = out_q.so;
    assign so_oe = out_q.oe;
    assign protection_lock_flag = st_q.lock;
    assign soft_reset_enable = st_q.rst_en;
    assign permanent_lock_enable = st_q.perm_en;
    assign sector_cmd_allowed = st_q.sect_allow;
    assign soft_reset_go = st_q.soft_go;
    assign wel_clear = st_q.wel_clr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_lock_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_q.lock && wp_as && ce) |=> st_q.lock;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock fell while protect pin asserted");

    property p_soft_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        (soft_reset_req && !st_q.rst_en && ce) |=> !soft_reset_go;
    endproperty
    a_soft_gate: assert property (p_soft_gate)
        else $error("soft reset passed while disabled");

    property p_soft_keep;
        @(posedge clk_sys) disable iff (!rst_n)
        (soft_reset_req && !cs_rise) |=> $stable(st_q.lock) && $stable(st_q.rst_en);
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("soft reset changed lock or enable");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> st_q.stat.b1[FSSR_B1_RES] == FSSR_RES_VAL
            && st_q.stat.b2[FSSR_B2_RES_HI:FSSR_B2_RES_LO] == FSSR_B2_RES_VAL;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bit not zero");

    property p_busy_both;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> st_q.stat.b1[FSSR_BUSY] == $past(core_in.busy)
            && st_q.stat.b2[FSSR_BUSY] == $past(core_in.busy);
    endproperty
    a_busy_both: assert property (p_busy_both)
        else $error("busy flag differs between bytes");

    property p_wpp;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> st_q.stat.b1[FSSR_B1_WPP] == $past(wp_s);
    endproperty
    a_wpp: assert property (p_wpp)
        else $error("pin status bit wrong");

    property p_w1_only;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && cap_s.kind == FSSR_WK_ONE && ce)
            |=> $stable(st_q.rst_en) && $stable(st_q.perm_en);
    endproperty
    a_w1_only: assert property (p_w1_only)
        else $error("byte one write touched byte two");

    property p_w2_only;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && cap_s.kind == FSSR_WK_TWO && ce) |=> $stable(st_q.lock);
    endproperty
    a_w2_only: assert property (p_w2_only)
        else $error("byte two write touched lock");

    property p_lock_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        sector_cmd_allowed == !protection_lock_flag;
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("sector commands allowed while locked");

    property p_hiz;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_s && $past(cs_s)) |-> !so_oe;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("output driven while deselected");

    property p_rd_only;
        @(negedge sck) disable iff (cs_n)
        out_q.oe |-> lk_q.mode == FSSR_FM_READ;
    endproperty
    a_rd_only: assert property (p_rd_only)
        else $error("output driven outside status read");

    property p_wrap;
        @(negedge sck) disable iff (cs_n)
        (lk_q.mode == FSSR_FM_READ && out_q.obit == FSSR_BIT_LAST && out_q.sel)
            |=> !out_q.sel && out_q.oe && out_q.obit == FSSR_BIT_FIRST;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("output stopped at byte wrap");

    c_wrap: cover property (@(negedge sck) disable iff (cs_n)
        out_q.oe && $fell(out_q.sel));
    c_lock_set: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st_q.lock));
    c_rst_en: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st_q.rst_en));
    c_soft_go: cover property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset_go);
endmodule // fssr_status_reg
`default_nettype wire

// File: verif/fssr_host_model.sv
// Purpose: host spi controller model driving the status register link
// Assumes: mode 0, sck idle low, sck stands still between frames
// Notes: 24 ns half period gives the 48 ns link clock
`timescale 1ns/1ns
`default_nettype none
module fssr_host_model (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic so,
    input wire logic so_oe
);
    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    localparam int HALF = 24;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // opcode then nbits more clocks; tx msb first, so caught on rise
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits,
                        output logic [31:0] rx, output logic oe_seen);
        logic [15:0] tx;
        tx = {op, dat};
        rx = 32'h0000_0000;
        oe_seen = 1'b1;
        cs_n = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            // past the data byte the line toggles, never a held value
            mosi = (i < 16) ? tx[15 - i] : ~mosi;
            #HALF sck = 1'b1;
            if (i >= 8) begin
                // an undriven line reads as the inverse, so a float shows up
                rx = {rx[30:0], so_oe ? so : ~so};
                oe_seen = oe_seen & so_oe;
            end
            #HALF sck = 1'b0;
        end
        #HALF cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule // fssr_host_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the status register block
// Assumes: writes need core_in.write_enable_latch high, as the core would set it
// Notes: only the later byte pair of each read is judged
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import fssr_pkg::*;
;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic wp_n = 1'b1;
    logic soft_reset_req = 1'b0;
    fssr_core_in_t core_in = '0;
    logic sck, cs_n, mosi, so, so_oe, lock, rst_en, perm, allowed, go, wclr;
    logic lock_m = 1'b0;
    logic rst_m = 1'b0;
    logic perm_m = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int go_cnt = 0;
    int wclr_cnt = 0;

    always #5 clk_sys = ~clk_sys;

    fssr_status_reg u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .sck(sck),
        .cs_n(cs_n), .mosi(mosi), .so(so), .so_oe(so_oe), .wp_n(wp_n), .core_in(core_in),
        .soft_reset_req(soft_reset_req), .protection_lock_flag(lock),
        .soft_reset_enable(rst_en), .permanent_lock_enable(perm),
        .sector_cmd_allowed(allowed), .soft_reset_go(go), .wel_clear(wclr));

    fssr_host_model u_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .so(so), .so_oe(so_oe));

    always @(posedge clk_sys) begin
        cycles++;
        if (rst_n && go === 1'b1) go_cnt++;
        if (rst_n && wclr === 1'b1) wclr_cnt++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_st();
        return {lock_m, 1'b0, core_in.ep_error, wp_n, core_in.software_protection_summary, core_in.write_enable_latch,
                core_in.busy, 3'h0, rst_m, perm_m, core_in.prog_susp,
                core_in.erase_susp, core_in.busy};
    endfunction

    task automatic settle();
        repeat (10) @(posedge clk_sys);
        #1;
    endtask

    // four bytes read, the later pair judged as the status
    task automatic rd_chk();
        logic [31:0] rx;
        logic oe;
        u_host.xfer(FSSR_OP_RD_STAT, 8'h00, 32, rx, oe);
        chk({15'h0000, oe}, 16'h0001);
        chk(rx[15:0], exp_st());
        settle();
    endtask

    task automatic wr(input logic [7:0] op, input logic [7:0] dat, input int nbits);
        logic [31:0] rx;
        logic oe;
        u_host.xfer(op, dat, nbits, rx, oe);
        settle();
    endtask

    function automatic logic [15:0] regs();
        return {12'h000, lock, rst_en, perm, allowed};
    endfunction

    task automatic wr1(input logic wp, input logic [7:0] dat, input logic exp);
        int w0;
        wp_n = wp;
        settle();
        w0 = wclr_cnt;
        wr(FSSR_OP_WR_STAT1, dat, 8);
        lock_m = exp;
        chk(regs(), {12'h000, exp, rst_m, perm_m, ~exp});
        chk(16'(wclr_cnt - w0), 16'h0001);
    endtask

    task automatic pulse_rst(input int exp_go);
        int g0;
        g0 = go_cnt;
        soft_reset_req = 1'b1;
        @(posedge clk_sys);
        #1 soft_reset_req = 1'b0;
        settle();
        chk(16'(go_cnt - g0), 16'(exp_go));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fields();
        fssr_core_in_t pat [4];
        pat = '{7'h55, 7'h2A, 7'h7F, 7'h08};
        for (int k = 0; k < 4; k++) begin
            core_in = pat[k];
            wp_n = k[0];
            settle();
            rd_chk();
        end
        $display("test fields done");
    endtask

    task automatic t_lock();
        core_in = 7'h04;
        wp_n = 1'b1;
        wr1(1'b1, 8'hFF, 1'b1);
        rd_chk();
        wr1(1'b0, 8'h00, 1'b1);
        wr1(1'b1, 8'h00, 1'b0);
        wr1(1'b0, 8'h80, 1'b1);
        $display("test lock done");
    endtask

    task automatic t_byte_two();
        wr(FSSR_OP_WR_STAT2, 8'hFF, 16);
        rst_m = 1'b1;
        perm_m = 1'b1;
        chk(regs(), 16'h000E);
        rd_chk();
        pulse_rst(1);
        chk(regs(), 16'h000E);
        ce = 1'b0;
        pulse_rst(0);
        ce = 1'b1;
        chk(regs(), 16'h000E);
        wr(FSSR_OP_WR_STAT2, 8'h00, 8);
        rst_m = 1'b0;
        perm_m = 1'b0;
        pulse_rst(0);
        chk(regs(), 16'h0008);
        $display("test byte two done");
    endtask

    task automatic t_refuse();
        logic [31:0] rx;
        logic oe;
        int w0;
        core_in = 7'h00;
        wr(FSSR_OP_WR_STAT2, 8'hFF, 8);
        chk(regs(), 16'h0008);
        core_in = 7'h04;
        w0 = wclr_cnt;
        wr(FSSR_OP_WR_STAT2, 8'hFF, 4);
        chk(regs(), 16'h0008);
        chk(16'(wclr_cnt - w0), 16'h0001);
        w0 = wclr_cnt;
        wr(FSSR_OP_WR_STAT2, 8'hFF, 12);
        chk(regs(), 16'h0008);
        chk(16'(wclr_cnt - w0), 16'h0001);
        w0 = wclr_cnt;
        u_host.xfer(8'hA5, 8'h00, 16, rx, oe);
        settle();
        chk({15'h0000, oe}, 16'h0000);
        chk(16'(wclr_cnt - w0), 16'h0000);
        u_host.xfer(FSSR_OP_RD_STAT, 8'h00, 3, rx, oe);
        #1;
        chk({14'h0000, oe, so_oe}, 16'h0002);
        settle();
        rd_chk();
        $display("test refuse done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_reset();
        rst_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        lock_m = 1'b0;
        rst_m = 1'b0;
        perm_m = 1'b0;
        settle();
        chk(regs(), 16'h0001);
        rd_chk();
        $display("test reset done");
    endtask

    initial begin
        t_reset();
        t_fields();
        t_lock();
        t_byte_two();
        t_refuse();
        t_reset();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
